// ==== src/sse_pkg.sv ====
// Operation
// - Serial bytes buffered, segmented, sent as images
// - Input image: six data, diagnostic, status
// - Diagnostic byte holds five error flags
// - Diagnostics always shown regardless of enable
// - Link-ok is 1 until communication disturbed
// - Diagnosis message only when diagnostics released
// - Output ack echoes last accepted output sequence
// - Input sequence counts 0,1,2,3, wraps
// - Input valid-byte count states valid bytes
// - Status: link-ok, out ack, in seq, count
// - Output user data loaded into transmit buffer
// - Receive purge only while clear request low
// - Clear request falling edge sets link-ok
// - Control fields ignored while clear request low
// - Transmit purge only while clear request low
package sse_pkg;
  // ----------------------------------------
  // Image layout
  // ----------------------------------------
  localparam int unsigned USER_BYTES = 6;
  localparam int unsigned DIAG_BYTE = 6;
  localparam int unsigned CTRL_BYTE = 7;
  localparam int unsigned FLAG_BIT = 7;
  localparam int unsigned ACK_HI = 6;
  localparam int unsigned ACK_LO = 5;
  localparam int unsigned SEQ_HI = 4;
  localparam int unsigned SEQ_LO = 3;
  localparam int unsigned CNT_HI = 2;
  localparam int unsigned CNT_LO = 0;
  localparam logic [2:0] MAX_COUNT = 3'h6;
  // Diagnostic byte bit positions
  localparam int unsigned DIAG_OVFL_BIT = 7;
  localparam int unsigned DIAG_FRAME_BIT = 6;
  localparam int unsigned DIAG_HNDSH_BIT = 5;
  localparam int unsigned DIAG_HW_BIT = 4;
  localparam int unsigned DIAG_PRM_BIT = 3;
  // Purge byte bit positions
  localparam int unsigned PURGE_RX_BIT = 1;
  localparam int unsigned PURGE_TX_BIT = 0;
  // ----------------------------------------
  // Buffers and registers
  // ----------------------------------------
  localparam int unsigned BUF_DEPTH = 64;
  localparam int unsigned BUF_AW = 6;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_RXDATA = 4'h2;
  localparam logic [3:0] ADDR_TXDATA = 4'h3;
  localparam logic [3:0] ADDR_DIAG = 4'h4;
  localparam logic [3:0] ADDR_LEVELS = 4'h5;
  localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;
  localparam logic [7:0] DIAG_RESET = 8'h00;
  localparam logic CTRL_DIAG_EN_RESET = 1'b0;
endpackage : sse_pkg

// ==== src/sse_buf_mem.sv ====
`timescale 1ns/100ps
`default_nettype none
// Byte memory with registered read data
module sse_buf_mem (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [5:0] waddr_i,
  input wire logic [7:0] wdata_i,
  input wire logic [5:0] raddr_i,
  output logic [7:0] rdata_o
);
  // Storage, no reset needed for data
  logic [7:0] mem_q [0:63];

  // ----------------------------------------
  // Write and registered read
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end
endmodule : sse_buf_mem
`default_nettype wire

// ==== src/sse_top.sv ====
// Design decisions made here: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
// Segment exchange between a serial byte stream and 8-byte images
module sse_top (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // Serial side receive bytes (same clock domain)
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  // Serial side transmit bytes
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  // Serial error events
  input wire logic framing_err_i,
  input wire logic handshake_err_i,
  input wire logic hw_fault_i,
  input wire logic param_err_i,
  // Controller images, output_image strobed by out_img_valid_i
  input wire logic out_img_valid_i,
  input wire logic [63:0] output_image_i,
  input wire logic in_img_req_i,
  output logic [63:0] input_image_o,
  output logic in_img_valid_o,
  output logic diag_msg_o,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  // ----------------------------------------
  // Reset synchroniser
  // ----------------------------------------
  logic rst_s1_q, rst_n_q; // Two-stage release
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  // ----------------------------------------
  // Control byte decode
  // ----------------------------------------
  wire logic [7:0] ctrl_b = output_image_i[8*sse_pkg::CTRL_BYTE +: 8];
  wire logic [7:0] purge_b = output_image_i[8*sse_pkg::DIAG_BYTE +: 8];
  wire logic clr_req = ctrl_b[sse_pkg::FLAG_BIT]; // link_ok_clear_req
  wire logic [1:0] in_segment_ack = ctrl_b[sse_pkg::ACK_HI:sse_pkg::ACK_LO];
  wire logic [1:0] out_segment_seq = ctrl_b[sse_pkg::SEQ_HI:sse_pkg::SEQ_LO];
  wire logic [2:0] out_valid_byte_count = ctrl_b[sse_pkg::CNT_HI:sse_pkg::CNT_LO];
  wire logic rx_purge = out_img_valid_i & purge_b[sse_pkg::PURGE_RX_BIT] & ~clr_req;
  wire logic tx_purge = out_img_valid_i & purge_b[sse_pkg::PURGE_TX_BIT] & ~clr_req;

  // Clear request acts as the handshake gate; low ignores counters
  logic clr_prev_q; // Last sampled clear request
  logic [1:0] out_seq_prev_q; // Last taken output sequence
  logic [1:0] out_segment_ack_q; // Echo returned in status
  logic [1:0] last_in_ack_q; // Last controller acknowledge
  // New output segment: clear high and sequence changed
  wire logic new_out_seg = out_img_valid_i & clr_req & (out_segment_seq != out_seq_prev_q);
  wire logic cnt_ok = out_valid_byte_count <= sse_pkg::MAX_COUNT;

  // ----------------------------------------
  // Buffer pointers (64-entry byte buffers)
  // ----------------------------------------
  logic [6:0] rx_wr_q, rx_rd_q, tx_wr_q, tx_rd_q; // Extra bit tells full from empty
  wire logic [6:0] rx_lvl = rx_wr_q - rx_rd_q;
  wire logic [6:0] tx_lvl = tx_wr_q - tx_rd_q;
  wire logic rx_full = rx_lvl[6];
  wire logic rx_push = rx_valid_i & ~rx_full;
  // Loss of a byte on a full buffer is reported, not hidden
  wire logic rx_lost = rx_valid_i & rx_full;
  // A new segment is only built once the controller has acked the last one
  logic [1:0] in_seq_q; // in_segment_seq
  // Strobed copy of the acknowledge; the image bus is stale between strobes
  wire logic in_acked = (last_in_ack_q == in_seq_q) | ~in_img_valid_o;
  wire logic [2:0] seg_len = (rx_lvl > 7'(sse_pkg::USER_BYTES)) ? sse_pkg::MAX_COUNT
                                                                : rx_lvl[2:0];

  // Receive memory is read through a gather FSM, one byte per cycle
  typedef enum logic [1:0] {SSE_IDLE, SSE_READ, SSE_SEND} sse_gst_t;
  sse_gst_t gst_q;
  logic [2:0] gcnt_q; // Bytes requested so far
  logic [2:0] glen_q; // Length of segment being built
  logic [2:0] img_cnt_q; // Count shown with the current image
  logic [2:0] gdone_q; // Bytes landed in image
  logic gpend_q; // A read is in flight
  logic [47:0] seg_q; // Assembled user bytes

  wire logic [7:0] rx_rdata;
  wire logic [7:0] tx_rdata;
  wire logic rx_rd_en = (gst_q == SSE_READ) & (gcnt_q < glen_q);
  wire logic tx_push_any = new_out_seg & cnt_ok & ~tx_purge;

  sse_buf_mem u_rx_mem (
    .clk_i(ref_clk_i),
    .we_i(rx_push),
    .waddr_i(rx_wr_q[5:0]),
    .wdata_i(rx_data_i),
    .raddr_i(rx_rd_q[5:0]),
    .rdata_o(rx_rdata)
  );

  // Transmit side uses the same registered-read memory
  logic [2:0] tx_load_q; // Bytes left to load from latched image
  logic [47:0] tx_seg_q; // Latched output user bytes
  wire logic tx_space = tx_lvl <= 7'(64 - sse_pkg::USER_BYTES);
  wire logic tx_load = (tx_load_q != 3'h0);
  // Byte k of segment sits in image byte 5-k
  wire logic [7:0] tx_load_byte = tx_seg_q[8*(sse_pkg::USER_BYTES-1) +: 8];
  // Level seen one cycle ago, so the registered read data are fresh
  logic tx_ne_q;
  sse_buf_mem u_tx_mem (
    .clk_i(ref_clk_i),
    .we_i(tx_load),
    .waddr_i(tx_wr_q[5:0]),
    .wdata_i(tx_load_byte),
    .raddr_i(tx_rd_q[5:0]),
    .rdata_o(tx_rdata)
  );

  // ----------------------------------------
  // Link-ok flag and diagnostics
  // ----------------------------------------
  logic link_ok_q;
  logic [7:0] diag_q; // Sticky diagnostic flags
  logic diag_en_q; // 0 means diagnostics released
  wire logic disturb = rx_lost | framing_err_i | handshake_err_i | hw_fault_i | param_err_i;

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      link_ok_q <= 1'b1;
      diag_q <= sse_pkg::DIAG_RESET;
      clr_prev_q <= 1'b0;
      diag_msg_o <= 1'b0;
    end else begin
      diag_msg_o <= 1'b0;
      if (out_img_valid_i) begin
        clr_prev_q <= clr_req;
      end
      if (disturb) begin
        link_ok_q <= 1'b0; // Only controller restores it
        diag_q[sse_pkg::DIAG_OVFL_BIT] <= diag_q[sse_pkg::DIAG_OVFL_BIT] | rx_lost;
        diag_q[sse_pkg::DIAG_FRAME_BIT] <= diag_q[sse_pkg::DIAG_FRAME_BIT] | framing_err_i;
        diag_q[sse_pkg::DIAG_HNDSH_BIT] <= diag_q[sse_pkg::DIAG_HNDSH_BIT] | handshake_err_i;
        diag_q[sse_pkg::DIAG_HW_BIT] <= diag_q[sse_pkg::DIAG_HW_BIT] | hw_fault_i;
        diag_q[sse_pkg::DIAG_PRM_BIT] <= diag_q[sse_pkg::DIAG_PRM_BIT] | param_err_i;
        if (link_ok_q & ~diag_en_q) begin
          diag_msg_o <= 1'b1;
        end
      end else if (out_img_valid_i & clr_prev_q & ~clr_req) begin
        link_ok_q <= 1'b1; // Falling clear edge; a new error wins
        diag_q <= sse_pkg::DIAG_RESET;
      end
    end
  end

  // ----------------------------------------
  // Output segment acceptance
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      out_seq_prev_q <= 2'h3; // First segment with sequence 0 counts as new
      out_segment_ack_q <= 2'h0;
      last_in_ack_q <= 2'h3; // Nothing acknowledged before the first image
      tx_load_q <= 3'h0;
      tx_seg_q <= '0;
    end else begin
      if (out_img_valid_i & clr_req) begin
        last_in_ack_q <= in_segment_ack;
      end
      if (tx_push_any & ~tx_load & tx_space) begin
        out_seq_prev_q <= out_segment_seq;
        out_segment_ack_q <= out_segment_seq; // Echo of accepted segment
        tx_seg_q <= output_image_i[47:0]; // Segment byte 0 already on top
        tx_load_q <= out_valid_byte_count;
      end else if (tx_load) begin
        tx_seg_q <= tx_seg_q << 8;
        tx_load_q <= tx_load_q - 3'h1;
      end
    end
  end

  // ----------------------------------------
  // Transmit buffer and serial output
  // ----------------------------------------
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      tx_wr_q <= 7'h00;
      tx_rd_q <= 7'h00;
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
      tx_ne_q <= 1'b0;
    end else if (tx_purge) begin
      tx_wr_q <= 7'h00;
      tx_rd_q <= 7'h00;
      tx_valid_o <= 1'b0;
      tx_ne_q <= 1'b0;
    end else begin
      if (tx_load) begin
        tx_wr_q <= tx_wr_q + 7'h01;
      end
      tx_ne_q <= (tx_lvl != 7'h00);
      if (tx_valid_o & tx_ready_i) begin
        tx_valid_o <= 1'b0;
      end else if (~tx_valid_o & tx_ne_q & (tx_lvl != 7'h00)) begin
        tx_valid_o <= 1'b1;
        tx_data_o <= tx_rdata;
        tx_rd_q <= tx_rd_q + 7'h01;
      end
    end
  end

  // ----------------------------------------
  // Input segment gather and image build
  // ----------------------------------------
  wire logic [7:0] status_b = {link_ok_q, out_segment_ack_q, in_seq_q, img_cnt_q};
  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      gst_q <= SSE_IDLE;
      gcnt_q <= 3'h0;
      glen_q <= 3'h0;
      img_cnt_q <= 3'h0;
      gdone_q <= 3'h0;
      gpend_q <= 1'b0;
      seg_q <= '0;
      in_seq_q <= 2'h3;
      rx_wr_q <= 7'h00;
      rx_rd_q <= 7'h00;
      input_image_o <= '0;
      in_img_valid_o <= 1'b0;
    end else if (rx_purge) begin
      rx_wr_q <= 7'h00;
      rx_rd_q <= 7'h00;
      gst_q <= SSE_IDLE;
      gpend_q <= 1'b0;
    end else begin
      if (rx_push) begin
        rx_wr_q <= rx_wr_q + 7'h01;
      end
      gpend_q <= rx_rd_en;
      if (gpend_q) begin
        seg_q[8*(sse_pkg::USER_BYTES-1) - 8*gdone_q +: 8] <= rx_rdata;
        gdone_q <= gdone_q + 3'h1;
      end
      // Diagnostics refresh every cycle except a receive purge cycle, enable setting notwithstanding
      input_image_o[8*sse_pkg::DIAG_BYTE +: 8] <= diag_q;
      case (gst_q)
        SSE_IDLE: begin
          if (in_img_req_i & in_acked & (rx_lvl != 7'h00)) begin
            glen_q <= seg_len;
            gcnt_q <= 3'h0;
            gdone_q <= 3'h0;
            seg_q <= '0;
            gst_q <= SSE_READ;
          end
        end
        SSE_READ: begin
          if (rx_rd_en) begin
            rx_rd_q <= rx_rd_q + 7'h01;
            gcnt_q <= gcnt_q + 3'h1;
          end else if (~gpend_q) begin
            gst_q <= SSE_SEND;
          end
        end
        SSE_SEND: begin
          in_seq_q <= in_seq_q + 2'h1; // Wraps 3 to 0
          input_image_o[47:0] <= seg_q;
          input_image_o[8*sse_pkg::CTRL_BYTE +: 8] <= {link_ok_q, out_segment_ack_q,
                                                        in_seq_q + 2'h1, glen_q};
          in_img_valid_o <= 1'b1;
          img_cnt_q <= glen_q; // Count moves only with its own data
          gst_q <= SSE_IDLE;
        end
        default: gst_q <= SSE_IDLE;
      endcase
      if (gst_q != SSE_SEND) begin
        input_image_o[8*sse_pkg::CTRL_BYTE +: 8] <= status_b;
      end
    end
  end

  // ----------------------------------------
  // Avalon-MM slave, one wait state
  // ----------------------------------------
  logic ack_q; // Answer phase
  wire logic [31:0] rd_mux =
      (avs_address == sse_pkg::ADDR_CTRL) ? {31'h0, diag_en_q} :
      (avs_address == sse_pkg::ADDR_STATUS) ? {24'h0, status_b} :
      (avs_address == sse_pkg::ADDR_RXDATA) ? {24'h0, seg_q[47:40]} :
      (avs_address == sse_pkg::ADDR_TXDATA) ? {24'h0, tx_data_o} :
      (avs_address == sse_pkg::ADDR_DIAG) ? {24'h0, diag_q} :
      (avs_address == sse_pkg::ADDR_LEVELS) ? {9'h0, tx_lvl, 9'h0, rx_lvl} :
      sse_pkg::UNMAPPED_VAL;

  always_ff @(posedge ref_clk_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      ack_q <= 1'b0;
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0000_0000;
      diag_en_q <= sse_pkg::CTRL_DIAG_EN_RESET;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      avs_waitrequest <= ~((avs_read | avs_write) & ~ack_q);
      if ((avs_read | avs_write) & ~ack_q) begin
        avs_readdata <= avs_read ? rd_mux : 32'h0000_0000;
      end
      // Write lands on the edge that sees waitrequest low
      if (avs_write & ack_q & (avs_address == sse_pkg::ADDR_CTRL)) begin
        diag_en_q <= avs_writedata[0];
      end
    end
  end
endmodule : sse_top
`default_nettype wire

// ==== dv/sse_props.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Port checker
// ----------------------------------------
module sse_props (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_ready_i,
  input wire logic out_img_valid_i,
  input wire logic [63:0] output_image_i,
  input wire logic framing_err_i,
  input wire logic hw_fault_i,
  input wire logic [63:0] input_image_o,
  input wire logic in_img_valid_o,
  input wire logic diag_msg_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // Transmit purge taken from the controller image cuts the pending byte
  wire logic tx_cut = out_img_valid_i & output_image_i[48] & ~output_image_i[63];
  // Bus request, then a single-cycle answer
  sequence req_s;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence ans_s;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  // New input segment, seen as a sequence field change
  sequence seg_s;
    in_img_valid_o && $changed(input_image_o[60:59]);
  endsequence
  // Error event lands in its sticky flag
  property flag_p(ev, fl);
    in_img_valid_o && ev |-> ##[1:2] fl;
  endproperty
  bus_answer_a: assert property (req_s |-> ##[1:2] ans_s) else $error("bus answer missing");
  frame_flag_a: assert property (flag_p(framing_err_i, input_image_o[54]))
    else $error("framing flag not shown");
  hw_flag_a: assert property (flag_p(hw_fault_i, input_image_o[52]))
    else $error("hardware flag not shown");
  msg_pulse_a: assert property (diag_msg_o |=> !diag_msg_o)
    else $error("diagnosis message too long");
  msg_cause_a: assert property (diag_msg_o && in_img_valid_o |-> ##[0:2]
    (input_image_o[55:51] != 5'h00)) else $error("message without cause");
  image_stays_a: assert property (in_img_valid_o |=> in_img_valid_o)
    else $error("image valid dropped");
  count_limit_a: assert property (in_img_valid_o |-> input_image_o[58:56] <= 3'h6)
    else $error("valid count above six");
  seq_step_a: assert property (seg_s |->
    input_image_o[60:59] == 2'($past(input_image_o[60:59]) + 2'h1)) else $error("sequence skipped");
  tx_hold_a: assert property (tx_valid_o && !tx_ready_i && !tx_cut |=>
    tx_valid_o && $stable(tx_data_o)) else $error("tx byte not held");
  tx_purge_a: assert property (tx_cut |=> !tx_valid_o)
    else $error("tx purge ignored");
endmodule : sse_props

bind sse_top sse_props chk_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest), .tx_valid_o(tx_valid_o),
  .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .out_img_valid_i(out_img_valid_i),
  .output_image_i(output_image_i), .framing_err_i(framing_err_i),
  .hw_fault_i(hw_fault_i), .input_image_o(input_image_o), .in_img_valid_o(in_img_valid_o),
  .diag_msg_o(diag_msg_o));
`default_nettype wire

// ==== dv/sse_plc_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Controller model
// ----------------------------------------
module sse_plc_model (
  input wire logic ref_clk_i,
  input wire logic [63:0] input_image_o,
  input wire logic in_img_valid_o,
  output logic img_valid_o,
  output logic [63:0] img_o,
  output logic req_o
);
  logic [1:0] seq_q = 2'h0; // Next output sequence
  logic [1:0] last_q = 2'h0; // Last input sequence seen
  int gaps = 0; // Lost segment count
  initial begin
    img_valid_o = 1'b0;
    img_o = '0;
    req_o = 1'b0;
  end
  // Gap watch on the input sequence, the device cannot see it
  always @(posedge ref_clk_i) begin
    if (in_img_valid_o === 1'b1 && input_image_o[60:59] !== last_q) begin
      if (input_image_o[60:59] !== 2'(last_q + 2'h1)) gaps++;
      last_q <= input_image_o[60:59];
    end
  end
  // Ready level for new input segments
  task set_req(input logic v);
    req_o <= v;
  endtask : set_req
  // One output image; ack echoes the newest input sequence
  task send(input logic flag, input logic [7:0] purge, input logic [2:0] cnt,
            input logic [47:0] data);
    @(posedge ref_clk_i);
    img_valid_o <= 1'b1;
    img_o <= {flag, input_image_o[60:59], seq_q, cnt, purge, data};
    seq_q <= seq_q + 2'h1;
    @(posedge ref_clk_i);
    img_valid_o <= 1'b0;
    img_o <= ~img_o; // Stale bus shows no old value
  endtask : send
endmodule : sse_plc_model
`default_nettype wire

// ==== dv/sse_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
// ----------------------------------------
// Bench top
// ----------------------------------------
module tb;
  logic ref_clk_i = 1'b0, nrst_i = 1'b0, rx_valid_i = 1'b0, tx_ready_i = 1'b0;
  logic [7:0] rx_data_i = 8'h00, tx_data_o;
  logic [3:0] err_q = 4'h0; // {param, hw, handshake, framing}
  logic tx_valid_o, out_img_valid_i, in_img_req_i, in_img_valid_o, diag_msg_o;
  logic [63:0] output_image_i, input_image_o;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
  logic [1:0] s;
  int fails = 0, cmp_count = 0, n, p;
  sse_top dut_u (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
    .tx_ready_i(tx_ready_i), .framing_err_i(err_q[0]), .handshake_err_i(err_q[1]),
    .hw_fault_i(err_q[2]), .param_err_i(err_q[3]), .out_img_valid_i(out_img_valid_i),
    .output_image_i(output_image_i), .in_img_req_i(in_img_req_i),
    .input_image_o(input_image_o), .in_img_valid_o(in_img_valid_o), .diag_msg_o(diag_msg_o),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  sse_plc_model plc_u (.ref_clk_i(ref_clk_i), .input_image_o(input_image_o),
    .in_img_valid_o(in_img_valid_o), .img_valid_o(out_img_valid_i),
    .img_o(output_image_i), .req_o(in_img_req_i));
  initial forever #50 ref_clk_i = ~ref_clk_i;
  // Avalon cycle held until waitrequest is seen low
  task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    n = 0;
    @(posedge ref_clk_i);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do begin @(posedge ref_clk_i); n++; end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    `CHK("bus wait", 1'b0, avs_waitrequest);
  endtask : bus
  task push(input logic [7:0] v);
    @(posedge ref_clk_i);
    rx_valid_i <= 1'b1;
    rx_data_i <= v;
    @(posedge ref_clk_i);
    rx_valid_i <= 1'b0;
  endtask : push
  task err_pulse(input logic [3:0] m);
    @(posedge ref_clk_i);
    err_q <= m;
    @(posedge ref_clk_i);
    err_q <= 4'h0;
    p = 0;
    repeat (6) begin @(posedge ref_clk_i); if (diag_msg_o === 1'b1) p++; end
  endtask : err_pulse
  task wait_seq(input logic [1:0] q);
    n = 0;
    while (!(in_img_valid_o === 1'b1 && input_image_o[60:59] === q) && n < 300) begin
      @(posedge ref_clk_i);
      n++;
    end
    `CHK("img seq", q, input_image_o[60:59]);
  endtask : wait_seq
  task t_regs;
    bus(0, sse_pkg::ADDR_CTRL, 32'h0);
    `CHK("ctrl", sse_pkg::CTRL_DIAG_EN_RESET, rd[0]);
    bus(0, sse_pkg::ADDR_DIAG, 32'h0);
    `CHK("diag", sse_pkg::DIAG_RESET, rd[7:0]);
    bus(1, 4'hF, 32'hFFFF_FFFF);
    bus(0, 4'hF, 32'h0);
    `CHK("unmapped", sse_pkg::UNMAPPED_VAL, rd);
    bus(0, sse_pkg::ADDR_STATUS, 32'h0);
    `CHK("link ok", 1'b1, rd[7]);
    $display("TB: t_regs done");
  endtask : t_regs
  task t_rx;
    for (int i = 0; i < 8; i++) push(8'h10 + 8'(i));
    plc_u.set_req(1'b1);
    wait_seq(2'h0);
    `CHK("seg0 data", 48'h1011_1213_1415, input_image_o[47:0]);
    `CHK("seg0 count", 3'h6, input_image_o[58:56]);
    `CHK("seg0 flag", 1'b1, input_image_o[63]);
    plc_u.send(1'b1, 8'h00, 3'h0, 48'h0);
    wait_seq(2'h1);
    `CHK("seg1 data", 16'h1617, input_image_o[47:32]);
    `CHK("seg1 count", 3'h2, input_image_o[58:56]);
    bus(0, sse_pkg::ADDR_RXDATA, 32'h0);
    `CHK("rx data reg", 8'h16, rd[7:0]);
    $display("TB: t_rx done");
  endtask : t_rx
  task t_tx;
    s = plc_u.seq_q;
    plc_u.send(1'b1, 8'h00, 3'h3, 48'hA5A4_A3A2_A1A0);
    bus(0, sse_pkg::ADDR_STATUS, 32'h0);
    `CHK("out ack", s, rd[6:5]);
    bus(0, sse_pkg::ADDR_TXDATA, 32'h0);
    `CHK("tx data reg", 8'hA5, rd[7:0]);
    tx_ready_i <= 1'b1;
    n = 0;
    p = 0;
    while (p < 3 && n < 100) begin
      @(posedge ref_clk_i);
      n++;
      if (tx_valid_o === 1'b1 && tx_ready_i === 1'b1) begin
        `CHK("tx byte", 8'hA5 - 8'(p), tx_data_o);
        p++;
      end
    end
    `CHK("tx bytes", 3, p);
    tx_ready_i <= 1'b0;
    plc_u.send(1'b1, 8'h00, 3'h7, 48'h0);
    plc_u.send(1'b0, 8'h00, 3'h2, 48'h0);
    bus(0, sse_pkg::ADDR_STATUS, 32'h0);
    `CHK("ack kept", s, rd[6:5]);
    $display("TB: t_tx done");
  endtask : t_tx
  task t_link;
    err_pulse(4'h1);
    `CHK("diag msg", 1, p);
    repeat (20) @(posedge ref_clk_i);
    bus(0, sse_pkg::ADDR_STATUS, 32'h0);
    `CHK("link down", 1'b0, rd[7]);
    plc_u.send(1'b1, 8'h00, 3'h0, 48'h0);
    plc_u.send(1'b0, 8'h00, 3'h0, 48'h0);
    bus(0, sse_pkg::ADDR_STATUS, 32'h0);
    `CHK("link back", 1'b1, rd[7]);
    bus(1, sse_pkg::ADDR_CTRL, 32'h1);
    err_pulse(4'hE);
    `CHK("blocked msg", 0, p);
    bus(0, sse_pkg::ADDR_DIAG, 32'h0);
    `CHK("diag flags", 8'h38, rd[7:0]);
    plc_u.send(1'b1, 8'h00, 3'h0, 48'h0);
    plc_u.send(1'b0, 8'h00, 3'h0, 48'h0);
    $display("TB: t_link done");
  endtask : t_link
  task t_purge;
    plc_u.set_req(1'b0);
    for (int i = 0; i < 3; i++) push(8'h40 + 8'(i));
    plc_u.send(1'b1, 8'h00, 3'h6, 48'h0);
    plc_u.send(1'b1, 8'h03, 3'h0, 48'h0);
    bus(0, sse_pkg::ADDR_LEVELS, 32'h0);
    `CHK("rx kept", 7'h3, rd[6:0]);
    `CHK("tx kept", 1'b1, rd[22:16] != 7'h0);
    plc_u.send(1'b0, 8'h03, 3'h0, 48'h0);
    bus(0, sse_pkg::ADDR_LEVELS, 32'h0);
    `CHK("purged", 7'h0, rd[6:0] | rd[22:16]);
    $display("TB: t_purge done");
  endtask : t_purge
  task give_verdict;
    $display("TB: fails=%0d compares=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // Hang guard, far beyond the expected run
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    fails++;
    give_verdict();
  end
  initial begin
    repeat (12) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge ref_clk_i);
    t_regs();
    t_rx();
    t_tx();
    t_link();
    t_purge();
    `CHK("seq gaps", 0, plc_u.gaps);
    give_verdict();
  end
endmodule : tb
`default_nettype wire
